//--- inc/ocr_pkg.sv
/*
  Package for the over-current fault responder: command codes, field
  positions, reset values, state codes and the command request carrier.
  Assumes one clock domain and a PMBus transport decoded elsewhere.
*/
package ocr_pkg;

  // ----------------------------------------------------------------------
  // Command codes of the registers
  // ----------------------------------------------------------------------
  localparam logic [7:0] OCR_CMD_THRESHOLD = 8'h46; // Fault threshold
  localparam logic [7:0] OCR_CMD_ACTION = 8'h47; // Response setting
  localparam logic [7:0] OCR_CMD_FLOOR = 8'h48; // Low-voltage floor
  localparam logic [7:0] OCR_CMD_UNIT = 8'hd2; // Delay time unit

  // ----------------------------------------------------------------------
  // Field positions of the response setting
  // ----------------------------------------------------------------------
  localparam int OCR_ACT_HI = 7; // Action field top bit
  localparam int OCR_ACT_LO = 6; // Action field low bit
  localparam int OCR_RETRY_HI = 5; // Restart-count top bit
  localparam int OCR_RETRY_LO = 3; // Restart-count low bit
  localparam int OCR_DLY_HI = 2; // Delay-count top bit
  localparam int OCR_DLY_LO = 0; // Delay-count low bit

  // Linear format: 5-bit exponent above an 11-bit mantissa
  localparam int OCR_LIN_EXP_LO = 11; // Exponent low bit
  localparam int OCR_LIN_BIAS = 16; // Shift bias so exponents are >= 0

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] OCR_ACT_BRICKWALL = 2'h0; // Limit, ignore voltage
  localparam logic [1:0] OCR_ACT_LV_LIMIT = 2'h1; // Limit above floor
  localparam logic [1:0] OCR_ACT_DELAY = 2'h2; // Limit for a delay
  localparam logic [1:0] OCR_ACT_HOLD_OFF = 2'h3; // Off while fault
  localparam logic [2:0] OCR_RETRY_NONE = 3'h0; // No restart attempt
  localparam logic [2:0] OCR_RETRY_ENDLESS = 3'h7; // Restart forever

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [15:0] OCR_RST_THRESHOLD = 16'h7bff; // Largest current
  localparam logic [7:0] OCR_RST_ACTION = 8'h00; // Brickwall, no retry
  localparam logic [15:0] OCR_RST_FLOOR = 16'h0000; // No floor
  localparam logic [15:0] OCR_RST_UNIT = 16'h0001; // One cycle per unit
  localparam logic [23:0] OCR_RST_TIMER = 24'h000000; // Idle timer

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OCR_ST_RUN = 3'b000, // Output on, no over-current
    OCR_ST_LIMIT = 3'b001, // Output on, current limited
    OCR_ST_RETRY_WAIT = 3'b010, // Output off, waiting to restart
    OCR_ST_LATCH_OFF = 3'b011, // Output off until fault clear
    OCR_ST_HOLD_OFF = 3'b100 // Output off while over-current lasts
  } ocr_state_t;

  typedef struct packed {
    logic valid; // Command strobe, one cycle
    logic write; // High for write, low for read
    logic [7:0] code; // Command code
    logic [15:0] wdata; // Write data, low bits used for bytes
  } ocr_cmd_t;

endpackage

//--- core/ocr_responder.sv
/*
  Over-current fault responder: holds the threshold, response, floor and
  delay-unit settings, compares measured current, limits, shuts down,
  restarts and reports the fault.
  Assumes PMBus transport, measurements and fault clear come from logic
  on clk_sys, already decoded into command strobes.
*/
//
// Function
// - Hold 16-bit linear-format current threshold.
// - Action bits 7:6, restart count bits 5:3.
// - Any action sets fault flag, alerts host.
// - Action 00 limits current indefinitely, brickwall.
// - Action 01 limits; shuts down below floor.
// - Action 10 limits for delay, then shuts.
// - Action 11 disables output while fault persists.
// - Count 000 stays off until cleared.
// - Counts 1..4 retry that often, then latch.
// - Count 111 retries without limit.
// - Restart interval equals the delay span, 2^n units.
// - Delay count means 2^n units; unit at D2.
// - Counts 5,6; endless retry ends on off/fault.
// - Floor is unsigned 16-bit voltage at 48.
`timescale 1ns/1ns
module ocr_responder (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire ocr_pkg::ocr_cmd_t cmd, // Command request
  output logic cmd_ack, // Command answered, one cycle
  output logic [15:0] cmd_rdata, // Read data, valid with cmd_ack
  input wire logic [15:0] iout_meas, // Output current, linear format
  input wire logic [15:0] vout_meas, // Output voltage, exponent -12
  input wire logic output_on_cmd, // Output commanded on
  input wire logic other_fault, // Another fault shut the unit down
  input wire logic fault_clear, // Clear faults, one cycle
  output logic output_enable, // Power stage enabled
  output logic current_limit, // Regulate current at threshold
  output logic oc_fault_flag, // Sticky over-current status bit
  output logic host_alert, // Host notification, level
  output logic [2:0] retries_left // Restart attempts remaining
);
  import ocr_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] threshold; // Over-current threshold
    logic [7:0] action; // Response setting
    logic [15:0] floor; // Low-voltage floor
    logic [15:0] unit; // Delay unit in clock cycles
    ocr_state_t state; // Response state
    logic [23:0] timer; // Delay and restart timer
    logic [2:0] left; // Restart attempts remaining
    logic flag; // Sticky fault flag
    logic ack; // Command answer strobe
    logic [15:0] rdata; // Read data
    logic out_en; // Output enable
    logic limit; // Current limit active
  } ocr_regs_t;

  ocr_regs_t r; // Registered state
  ocr_regs_t next_r; // Next state

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Linear value to a common fixed point; the bias keeps shifts positive
  function automatic logic signed [42:0] lin_value(input logic [15:0] v);
    logic signed [42:0] m;
    logic [5:0] sh;
    m = 43'(signed'(v[OCR_LIN_EXP_LO-1:0]));
    sh = 6'(signed'(v[15:OCR_LIN_EXP_LO])) + 6'(OCR_LIN_BIAS);
    return m <<< sh;
  endfunction

  // Cycles of a delay: 2^n units
  function automatic logic [23:0] delay_cycles(input logic [15:0] u,
                                               input logic [2:0] n);
    return {8'h00, u} << n;
  endfunction

  logic over_current; // Current at or above threshold
  logic below_floor; // Voltage under the floor
  logic [1:0] act; // Selected action
  logic [2:0] retry; // Restart-count setting
  logic [23:0] delay; // Delay in cycles
  logic [23:0] timer_inc; // Timer plus one

  assign over_current = lin_value(iout_meas) >= lin_value(r.threshold);
  assign below_floor = vout_meas < r.floor;
  assign act = r.action[OCR_ACT_HI:OCR_ACT_LO];
  assign retry = r.action[OCR_RETRY_HI:OCR_RETRY_LO];
  assign delay = delay_cycles(r.unit, r.action[OCR_DLY_HI:OCR_DLY_LO]);
  assign timer_inc = r.timer + 24'h000001;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // One process for everything: registers, flag, and the response machine
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    // Command decode; unmapped codes read as zero, writes are dropped
    if (cmd.valid) begin
      next_r.ack = 1'b1;
      next_r.rdata = 16'h0000;
      case (cmd.code)
        OCR_CMD_THRESHOLD: begin
          next_r.rdata = r.threshold;
          if (cmd.write) begin
            next_r.threshold = cmd.wdata;
          end
        end
        OCR_CMD_ACTION: begin
          next_r.rdata = {8'h00, r.action};
        end
        OCR_CMD_FLOOR: begin
          next_r.rdata = r.floor;
          if (cmd.write) begin
            next_r.floor = cmd.wdata;
          end
        end
        OCR_CMD_UNIT: begin
          next_r.rdata = r.unit;
          if (cmd.write) begin
            next_r.unit = cmd.wdata;
          end
        end
        default: begin
          next_r.rdata = 16'h0000;
        end
      endcase
    end
    // Shutdown and restart machine
    case (r.state)
      OCR_ST_RUN: begin
        if (over_current) begin
          // Action 11 drops the output, the others start limiting
          if (act == OCR_ACT_HOLD_OFF) begin
            next_r.state = OCR_ST_HOLD_OFF;
          end else begin
            next_r.state = OCR_ST_LIMIT;
            next_r.timer = OCR_RST_TIMER;
          end
        end
      end
      OCR_ST_LIMIT: begin
        if (!over_current) begin
          next_r.state = OCR_ST_RUN;
          next_r.timer = OCR_RST_TIMER;
        end else if (act == OCR_ACT_HOLD_OFF) begin
          // Switched to action 11 while limiting: drop, never latch
          next_r.state = OCR_ST_HOLD_OFF;
          next_r.timer = OCR_RST_TIMER;
        end else if ((act == OCR_ACT_LV_LIMIT && below_floor) ||
                     (act == OCR_ACT_DELAY && timer_inc >= delay)) begin
          // Shut down; a spent count latches, endless never does
          next_r.timer = OCR_RST_TIMER;
          if (retry == OCR_RETRY_ENDLESS) begin
            next_r.state = OCR_ST_RETRY_WAIT;
          end else if (retry == OCR_RETRY_NONE || r.left == 3'h0) begin
            next_r.state = OCR_ST_LATCH_OFF;
          end else begin
            next_r.state = OCR_ST_RETRY_WAIT;
          end
        end else begin
          next_r.timer = timer_inc;
        end
      end
      OCR_ST_RETRY_WAIT: begin
        if (!output_on_cmd || other_fault) begin
          next_r.state = OCR_ST_LATCH_OFF;
        end else if (timer_inc >= delay) begin
          // Start the next attempt; a limited count is decremented as it starts
          next_r.state = OCR_ST_RUN;
          next_r.timer = OCR_RST_TIMER;
          if (retry != OCR_RETRY_ENDLESS) begin
            next_r.left = r.left - 3'h1;
          end
        end else begin
          next_r.timer = timer_inc;
        end
      end
      OCR_ST_LATCH_OFF: begin
        if (fault_clear) begin
          next_r.state = OCR_ST_RUN;
        end
      end
      OCR_ST_HOLD_OFF: begin
        if (!over_current) begin
          next_r.state = OCR_ST_RUN;
        end
      end
      default: begin
        next_r.state = OCR_ST_LATCH_OFF;
      end
    endcase
    // Rewriting the setting or clearing faults reloads the attempts
    if (cmd.valid && cmd.write && cmd.code == OCR_CMD_ACTION) begin
      next_r.action = cmd.wdata[7:0];
      next_r.left = cmd.wdata[OCR_RETRY_HI:OCR_RETRY_LO];
    end else if (fault_clear) begin
      next_r.left = retry;
    end
    // New delay settings restart the timer so no span starts overrun
    if (cmd.valid && cmd.write &&
        (cmd.code == OCR_CMD_ACTION || cmd.code == OCR_CMD_UNIT)) begin
      next_r.timer = OCR_RST_TIMER;
    end
    // Sticky flag: an event in the clearing cycle still sets it
    if (fault_clear) begin
      next_r.flag = 1'b0;
    end
    if (over_current) begin
      next_r.flag = 1'b1;
    end
    // Outputs follow the next state so they come from flip-flops
    next_r.out_en = output_on_cmd && (next_r.state == OCR_ST_RUN ||
                                      next_r.state == OCR_ST_LIMIT);
    next_r.limit = next_r.state == OCR_ST_LIMIT;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Single register bank; reset loads constants only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r.threshold <= OCR_RST_THRESHOLD;
      r.action <= OCR_RST_ACTION;
      r.floor <= OCR_RST_FLOOR;
      r.unit <= OCR_RST_UNIT;
      r.state <= OCR_ST_RUN;
      r.timer <= OCR_RST_TIMER;
      r.left <= OCR_RST_ACTION[OCR_RETRY_HI:OCR_RETRY_LO];
      r.flag <= 1'b0;
      r.ack <= 1'b0;
      r.rdata <= 16'h0000;
      r.out_en <= 1'b0;
      r.limit <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign cmd_ack = r.ack;
  assign cmd_rdata = r.rdata;
  assign output_enable = r.out_en;
  assign current_limit = r.limit;
  assign oc_fault_flag = r.flag;
  assign host_alert = r.flag;
  assign retries_left = r.left;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic wr_act; // Response setting written this cycle
  assign wr_act = cmd.valid && cmd.write && cmd.code == OCR_CMD_ACTION;

  property p_thr_write;
    cmd.valid && cmd.write && cmd.code == OCR_CMD_THRESHOLD |=>
      r.threshold == $past(cmd.wdata) && cmd_ack;
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("threshold write lost");

  property p_act_write;
    wr_act |=> retries_left == $past(cmd.wdata[5:3]) &&
      r.action == $past(cmd.wdata[7:0]);
  endproperty
  a_act_write: assert property (p_act_write)
    else $error("response setting write lost");

  property p_flag;
    over_current |=> oc_fault_flag && host_alert;
  endproperty
  a_flag: assert property (p_flag)
    else $error("fault flag not set");

  property p_brick;
    r.state == OCR_ST_RUN && act == OCR_ACT_BRICKWALL && over_current
      |=> current_limit;
  endproperty
  a_brick: assert property (p_brick)
    else $error("brickwall limit not entered");

  property p_lv;
    r.state == OCR_ST_LIMIT && act == OCR_ACT_LV_LIMIT && over_current &&
      below_floor |=> !output_enable && !current_limit;
  endproperty
  a_lv: assert property (p_lv)
    else $error("no shutdown below floor");

  property p_delay;
    r.state == OCR_ST_LIMIT && act == OCR_ACT_DELAY |-> r.timer < delay;
  endproperty
  a_delay: assert property (p_delay)
    else $error("limit outlived its delay");

  property p_hold;
    (r.state == OCR_ST_RUN || r.state == OCR_ST_LIMIT) &&
      act == OCR_ACT_HOLD_OFF && over_current
      |=> !output_enable ##0 (r.state == OCR_ST_HOLD_OFF);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output not held off");

  property p_latch;
    r.state == OCR_ST_LATCH_OFF && !fault_clear |=> !output_enable &&
      r.state == OCR_ST_LATCH_OFF;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched output came back");

  property p_count;
    r.state == OCR_ST_LIMIT && !$past(wr_act) |->
      retry == OCR_RETRY_ENDLESS || retries_left <= retry;
  endproperty
  a_count: assert property (p_count)
    else $error("attempt count above setting");

  property p_endless;
    r.state == OCR_ST_LIMIT && retry == OCR_RETRY_ENDLESS && !wr_act
      |=> r.state != OCR_ST_LATCH_OFF;
  endproperty
  a_endless: assert property (p_endless)
    else $error("endless retry latched");

  property p_interval;
    r.state == OCR_ST_RETRY_WAIT |-> r.timer < delay && !output_enable;
  endproperty
  a_interval: assert property (p_interval)
    else $error("restart interval overrun");

  property p_stop;
    r.state == OCR_ST_RETRY_WAIT && other_fault |=>
      (r.state == OCR_ST_LATCH_OFF) [*2];
  endproperty
  a_stop: assert property (p_stop)
    else $error("retry did not stop");

  property p_reload;
    fault_clear && !wr_act |=> retries_left == $past(retry);
  endproperty
  a_reload: assert property (p_reload)
    else $error("attempts not reloaded");

  property p_back;
    r.state == OCR_ST_LIMIT && !over_current |=> r.state == OCR_ST_RUN &&
      r.timer == OCR_RST_TIMER;
  endproperty
  a_back: assert property (p_back)
    else $error("delay timer not reset");

  c_retry: cover property (r.state == OCR_ST_RETRY_WAIT ##1
    r.state == OCR_ST_RUN);
  c_latch: cover property (r.state == OCR_ST_LIMIT ##1
    r.state == OCR_ST_LATCH_OFF);
  c_hold: cover property (r.state == OCR_ST_HOLD_OFF ##1
    r.state == OCR_ST_RUN);

endmodule // ocr_responder

//--- verif/ocr_host.sv
/*
  Host controller model: issues one command at a time on the command
  carrier and returns the answer of the responder.
  Assumes the responder acks every command one cycle after taking it.
*/
`timescale 1ns/1ns
module ocr_host (
  input wire logic clk_sys, // System clock
  output ocr_pkg::ocr_cmd_t cmd, // Command request
  input wire logic cmd_ack, // Command answered
  input wire logic [15:0] cmd_rdata // Read data
);
  import ocr_pkg::*;

  // ----------------------------------------------------------------------
  // Idle carrier
  // ----------------------------------------------------------------------
  initial cmd = '0;

  // ----------------------------------------------------------------------
  // One command: strobe for one cycle, take the answer a cycle later
  // ----------------------------------------------------------------------
  // Released fields carry inverted values so stale data cannot pass
  task automatic xfer(input logic w, input logic [7:0] code,
                      input logic [15:0] d, output logic [15:0] rd,
                      output logic ack);
    @(negedge clk_sys);
    cmd <= '{valid: 1'b1, write: w, code: code, wdata: d};
    @(negedge clk_sys);
    cmd <= '{valid: 1'b0, write: ~w, code: ~code, wdata: ~d};
    ack = cmd_ack;
    rd = cmd_rdata;
  endtask
endmodule // ocr_host

//--- verif/ocr_responder_tb.sv
/*
  Self-checking bench of the over-current responder: register table,
  each response action, retry counting and reset.
  Assumes the host model drives commands; all inputs change at negedge.
*/
`timescale 1ns/1ns
module ocr_responder_tb;
  import ocr_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] code; // Command code
    logic [15:0] wdata; // Value written
    logic [15:0] rexp; // Value read back
  } ocr_row_t;
  logic clk_sys = 1'b0; // 100 MHz clock
  logic arst_n = 1'b0; // Reset, active low
  ocr_cmd_t cmd; // From host model
  logic cmd_ack;
  logic [15:0] cmd_rdata;
  logic [15:0] iout_meas = 16'h0008; // Below threshold, exponent 0
  logic [15:0] vout_meas = 16'h2000; // Above any floor used
  logic output_on_cmd = 1'b1;
  logic other_fault = 1'b0;
  logic fault_clear = 1'b0;
  logic output_enable, current_limit, oc_fault_flag, host_alert;
  logic [2:0] retries_left;
  logic [15:0] rd; // Last read data
  int checks = 0;
  int miscompares = 0;
  int n; // Cycle count of the last wait
  int rises; // Restart count in endless mode
  ocr_row_t rows [5] = '{
    '{8'h46, 16'h0010, 16'h0010}, '{8'h47, 16'h00ab, 16'h00ab},
    '{8'h48, 16'h1000, 16'h1000}, '{8'hd2, 16'h0002, 16'h0002},
    '{8'h99, 16'hffff, 16'h0000}}; // Unmapped: write dropped, reads 0

  always #5 clk_sys = ~clk_sys;

  ocr_host u_ocr_host (.clk_sys(clk_sys), .cmd(cmd), .cmd_ack(cmd_ack),
    .cmd_rdata(cmd_rdata));

  ocr_responder u_ocr_responder (.clk_sys(clk_sys), .arst_n(arst_n),
    .cmd(cmd), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata),
    .iout_meas(iout_meas), .vout_meas(vout_meas),
    .output_on_cmd(output_on_cmd), .other_fault(other_fault),
    .fault_clear(fault_clear), .output_enable(output_enable),
    .current_limit(current_limit), .oc_fault_flag(oc_fault_flag),
    .host_alert(host_alert), .retries_left(retries_left));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One command; every command must be acked
  task automatic rw(input logic w, input logic [7:0] code,
                    input logic [15:0] d);
    logic ack;
    u_ocr_host.xfer(w, code, d, rd, ack);
    check("cmd_ack", {15'h0, ack}, 16'h0001);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  // Count negedges until output_enable (0) or current_limit (1) is lvl
  task automatic wait_sig(input int sel, input logic lvl);
    n = 0;
    while (((sel == 0) ? output_enable : current_limit) !== lvl) begin
      @(negedge clk_sys);
      n++;
      if (n > 500) begin
        check("wait_bound", 16'h0001, 16'h0000);
        break;
      end
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog: the sequence needs a few thousand cycles at most
  // ----------------------------------------------------------------------
  initial begin
    #(50000 * 10);
    miscompares++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    cycles(16);
    arst_n = 1'b1;
    // Reset values of the register table
    rw(1'b0, OCR_CMD_THRESHOLD, 16'h0); check("rst_thr", rd, OCR_RST_THRESHOLD);
    rw(1'b0, OCR_CMD_ACTION, 16'h0); check("rst_act", rd, {8'h0, OCR_RST_ACTION});
    rw(1'b0, OCR_CMD_FLOOR, 16'h0); check("rst_floor", rd, OCR_RST_FLOOR);
    rw(1'b0, OCR_CMD_UNIT, 16'h0); check("rst_unit", rd, OCR_RST_UNIT);
    // Table rows: write then read back
    foreach (rows[i]) begin
      rw(1'b1, rows[i].code, rows[i].wdata);
      rw(1'b0, rows[i].code, 16'h0);
      check("readback", rd, rows[i].rexp);
    end
    // Rewriting the setting reloads the attempt counter
    rw(1'b1, OCR_CMD_ACTION, 16'h00a0);
    cycles(1); check("reload", {13'h0, retries_left}, 16'h0004);
    // Action 00: limit forever, flag and alert raised
    rw(1'b1, OCR_CMD_ACTION, 16'h0000);
    iout_meas = 16'h0020;
    cycles(60);
    check("bw_lim", {15'h0, current_limit}, 16'h0001);
    check("bw_oe", {15'h0, output_enable}, 16'h0001);
    check("flag", {15'h0, oc_fault_flag}, 16'h0001);
    check("alert", {15'h0, host_alert}, 16'h0001);
    // Action 11: off while the fault lasts, back on after
    rw(1'b1, OCR_CMD_ACTION, 16'h00c0);
    cycles(2); check("hold_off", {15'h0, output_enable}, 16'h0000);
    iout_meas = 16'h0008;
    cycles(2); check("hold_on", {15'h0, output_enable}, 16'h0001);
    // Action 01, no retry: limit above floor, latch below it
    rw(1'b1, OCR_CMD_ACTION, 16'h0040);
    iout_meas = 16'h0020;
    cycles(10); check("lv_lim", {15'h0, output_enable}, 16'h0001);
    vout_meas = 16'h0800;
    cycles(3); check("lv_off", {15'h0, output_enable}, 16'h0000);
    iout_meas = 16'h0008;
    vout_meas = 16'h2000;
    cycles(20); check("latch", {15'h0, output_enable}, 16'h0000);
    fault_clear = 1'b1;
    cycles(1);
    fault_clear = 1'b0;
    cycles(2); check("clr_on", {15'h0, output_enable}, 16'h0001);
    check("clr_flag", {15'h0, oc_fault_flag}, 16'h0000);
    // Action 10, one retry, delay 2 units of 2 cycles: span 4 cycles
    rw(1'b1, OCR_CMD_ACTION, 16'h0089);
    iout_meas = 16'h0020; // Short bursts restart the delay timer
    cycles(2);
    iout_meas = 16'h0008;
    cycles(2);
    iout_meas = 16'h0020;
    cycles(2);
    check("short", {15'h0, output_enable}, 16'h0001);
    iout_meas = 16'h0008;
    cycles(3);
    iout_meas = 16'h0020;
    wait_sig(1, 1'b1);
    wait_sig(0, 1'b0);
    check("dly_span", {15'h0, n >= 3 && n <= 5}, 16'h0001);
    wait_sig(0, 1'b1);
    check("retry_gap", {15'h0, n >= 3 && n <= 5}, 16'h0001);
    check("left", {13'h0, retries_left}, 16'h0000);
    wait_sig(0, 1'b0);
    cycles(30); check("spent", {15'h0, output_enable}, 16'h0000);
    iout_meas = 16'h0008;
    fault_clear = 1'b1;
    cycles(1);
    fault_clear = 1'b0;
    // Output commanded off gates the enable, back on when commanded
    output_on_cmd = 1'b0;
    cycles(2); check("cmd_off", {15'h0, output_enable}, 16'h0000);
    output_on_cmd = 1'b1;
    cycles(2); check("cmd_on", {15'h0, output_enable}, 16'h0001);
    // Endless retry with delay of one unit
    rw(1'b1, OCR_CMD_ACTION, 16'h00b8);
    iout_meas = 16'h0020;
    rises = 0;
    repeat (80) begin
      @(negedge clk_sys);
      if (output_enable === 1'b1 && current_limit === 1'b0) rises++;
    end
    check("endless", {15'h0, rises >= 5}, 16'h0001);
    other_fault = 1'b1;
    cycles(20); check("other", {15'h0, output_enable}, 16'h0000);
    other_fault = 1'b0;
    iout_meas = 16'h0008;
    // Reset in mid-run clears outputs and registers
    arst_n = 1'b0;
    cycles(2); check("rst_oe", {15'h0, output_enable}, 16'h0000);
    arst_n = 1'b1;
    rw(1'b0, OCR_CMD_ACTION, 16'h0); check("rst_act2", rd, {8'h0, OCR_RST_ACTION});
    print_verdict();
  end
endmodule // ocr_responder_tb
